// File: hw/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
	// Core clock and derived timing
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned POR_SEQ_NS = 1000;
	localparam int unsigned POR_SEQ_CYC =
		(POR_SEQ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned ARM_WINDOW_TCY = 1;
	localparam int unsigned REENTRY_TCY = 3;

	// Register byte offsets
	localparam logic [11:0] OFS_DSC = 12'h000;
	localparam logic [11:0] OFS_WSRC = 12'h004;
	localparam logic [11:0] OFS_SCR0 = 12'h008;
	localparam logic [11:0] OFS_SCR1 = 12'h00C;
	localparam logic [11:0] OFS_RCAUSE = 12'h010;
	localparam logic [11:0] OFS_STAT = 12'h014;

	// Field positions
	localparam int unsigned DSC_ARM = 15;
	localparam int unsigned DSC_BOR = 1;
	localparam int unsigned DSC_REL = 0;
	localparam int unsigned WS_EXTERNAL_IRQ_ZERO = 8;
	localparam int unsigned WS_FLT = 7;
	localparam int unsigned WS_WDT = 4;
	localparam int unsigned WS_MASTER_CLEAR_PIN = 2;
	localparam int unsigned WS_POR = 0;
	localparam int unsigned RC_DEXIT = 10;

	// Reset values
	localparam logic [15:0] SCR_RST = 16'h0000;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// Power-save operand
	localparam logic PS_SLEEP = 1'b0;
	localparam logic PS_IDLE = 1'b1;

	localparam int unsigned IO_W = 16;

	typedef enum logic [2:0] {
		ST_RUN, ST_SLEEP, ST_IDLE, ST_DEEP, ST_DEEP_EXIT
	} pmc_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pmc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pmc_apb_rsp_t;

	typedef struct packed {
		logic [IO_W-1:0] dir;
		logic [IO_W-1:0] lvl;
	} pmc_io_t;
endpackage
`default_nettype wire

// File: hw/pmc_top.sv
// Function
// - Sleep stops system clock and oscillator
// - Idle stops CPU, system clock keeps running
// - Sleep freezes pin direction and level
// - Clock monitor off during Sleep
// - Low-power RC kept on per watchdog/monitor
// - Watchdog cleared on Sleep or Idle entry
// - Sleep disables clocked peripherals
// - Interrupt, reset or watchdog ends Sleep/Idle
// - Resume on clock source held at entry
// - Idle wake restores CPU clock, fetch resumes
// - Coincident interrupt waits, then wakes
// - Deep Sleep stops all, freezes pins, unpowers memories
// - Deep exit on POR, clear pin, irq0, watchdog
// - Arm bit dropped if save not prompt
// - Arm bit cleared on Deep Sleep exit
// - Setting arm bit clears wake sources
// - Irq0 wakes only if enabled, on edge
// - Pending interrupts discarded on Deep entry
// - Deep exit is POR; scratch, wake kept
// - Wake events during POR sequence ignored
// - Release bit holds pins until cleared
// - Brownout in Deep: flag, re-arm, no wake
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module pmc_top #(
	parameter int unsigned DATA_W = 16,
	parameter int unsigned POR_CYC = pmc_pkg::POR_SEQ_CYC,
	parameter int unsigned ARM_TCY = pmc_pkg::ARM_WINDOW_TCY
) (
	input wire logic pclk, // Bus and core clock
	input wire logic presetn, // True power-on reset
	input wire pmc_pkg::pmc_apb_req_t apb_req, // APB request
	output pmc_pkg::pmc_apb_rsp_t apb_rsp, // APB answer
	input wire logic psave_req, // Power-save instruction executed
	input wire logic psave_mode, // Operand: 0 sleep, 1 idle
	input wire logic instr_tick, // One pulse per instruction cycle
	input wire logic irq_wake, // Enabled interrupt pending
	input wire logic dev_reset_req, // Any device reset event
	input wire logic wdt_enable, // System watchdog enabled
	input wire logic wdt_on_low_power_rc_osc, // Watchdog clocked by RC osc
	input wire logic failsafe_clock_monitor_enable, // Clock monitor enabled
	input wire logic wdt_timeout, // System watchdog time-out
	input wire logic master_clear_pin_pin_n, // Master-clear pin, low active
	input wire logic irq0_pin, // External irq 0 pin
	input wire logic irq0_en, // External irq 0 enabled
	input wire logic irq0_pol, // Irq 0 assertion level
	input wire logic deep_state_watchdog_timeout, // Deep watchdog time-out
	input wire logic por_event, // Supply POR seen while deep
	input wire logic deep_state_brownout_event, // Deep brownout detected
	input wire logic deep_state_brownout_cfg, // Deep brownout enabled
	input wire logic [2:0] clk_sel_in, // Selected clock source
	input wire pmc_pkg::pmc_io_t io_in, // Latch and direction
	output pmc_pkg::pmc_io_t io_out, // Pin control to pads
	output logic io_frozen, // Pins held
	output logic sysclk_en, // System clock source on
	output logic osc_en, // On-chip oscillator on
	output logic cpu_clk_en, // CPU clock gate
	output logic periph_clk_en, // Peripheral clock gate
	output logic low_power_rc_osc_en, // Low-power RC running
	output logic failsafe_clock_monitor_active, // Clock monitor active
	output logic wdt_clear, // Watchdog clear pulse
	output logic [2:0] clk_sel_out, // Clock source in use
	output logic cpu_resume, // Fetch resumes pulse
	output logic irq_flush, // Drop pending interrupts pulse
	output logic mem_pwr_en, // RAM and flash powered
	output logic core_rst_n, // Core reset, low active
	output logic por_rearm // Re-arm POR detect pulse
);
	import pmc_pkg::*;

	pmc_state_t state_q, state_d;
	logic arm_q, bor_q, rel_q, dexit_q;
	logic [15:0] wsrc_q;
	logic [DATA_W-1:0] scr0_q, scr1_q;
	logic [7:0] arm_age_q;
	logic [15:0] por_cnt_q;
	logic [2:0] clk_hold_q;
	pmc_io_t io_hold_q;
	logic irq0_en_q, irq0_prev_q;
	logic wr_en, rd_setup, addr_ok;
	logic deep_enter, deep_wake, sl_wake, irq0_hit;
	logic [15:0] wake_set;

	// APB decode; zero wait states
	assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_setup = apb_req.psel & ~apb_req.penable;
	always_comb begin
		case (apb_req.paddr)
			OFS_DSC, OFS_WSRC, OFS_SCR0, OFS_SCR1,
			OFS_RCAUSE, OFS_STAT: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// Irq 0 wakes on a change to its asserted level only
	assign irq0_hit = irq0_en_q & (irq0_pin != irq0_prev_q)
		& (irq0_pin == irq0_pol);

	// Deep wake causes; brownout deliberately absent
	assign deep_wake = por_event | ~master_clear_pin_pin_n | irq0_hit
		| deep_state_watchdog_timeout;
	assign sl_wake = irq_wake | dev_reset_req | wdt_timeout;
	assign deep_enter = psave_req & (psave_mode == PS_SLEEP) & arm_q;

	// Wake source bits, recorded only while truly in deep state
	always_comb begin
		wake_set = 16'h0000;
		if (state_q == ST_DEEP) begin
			wake_set[WS_POR] = por_event;
			wake_set[WS_MASTER_CLEAR_PIN] = ~master_clear_pin_pin_n;
			wake_set[WS_EXTERNAL_IRQ_ZERO] = irq0_hit;
			wake_set[WS_WDT] = deep_state_watchdog_timeout;
		end
	end

	// Mode sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				// Save wins over a coincident interrupt
				if (deep_enter) begin
					state_d = ST_DEEP;
				end else if (psave_req) begin
					state_d = (psave_mode == PS_IDLE) ? ST_IDLE : ST_SLEEP;
				end
			end
			ST_SLEEP, ST_IDLE: begin
				if (sl_wake) begin
					state_d = ST_RUN;
				end
			end
			ST_DEEP: begin
				if (deep_wake) begin
					state_d = ST_DEEP_EXIT;
				end
			end
			ST_DEEP_EXIT: begin
				if (por_cnt_q == 16'h0000) begin
					state_d = ST_RUN;
				end
			end
			default: state_d = ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// POR sequence length after a deep exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_cnt_q <= 16'h0000;
		end else if (state_q == ST_DEEP && state_d == ST_DEEP_EXIT) begin
			por_cnt_q <= 16'(POR_CYC - 1);
		end else if (por_cnt_q != 16'h0000) begin
			por_cnt_q <= por_cnt_q - 16'h0001;
		end
	end

	// Arm bit: software set, window drop, clear on exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_q <= 1'b0;
			arm_age_q <= 8'h00;
		end else if (state_q == ST_DEEP && state_d == ST_DEEP_EXIT) begin
			arm_q <= 1'b0;
		end else if (wr_en && apb_req.paddr == OFS_DSC) begin
			arm_q <= apb_req.pwdata[DSC_ARM];
			arm_age_q <= 8'h00;
		end else if (arm_q && state_q == ST_RUN && !deep_enter
			&& instr_tick) begin
			if (arm_age_q >= 8'(ARM_TCY)) begin
				arm_q <= 1'b0;
			end else begin
				arm_age_q <= arm_age_q + 8'h01;
			end
		end
	end

	// Brownout flag and release bit; hardware set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bor_q <= 1'b0;
			rel_q <= 1'b0;
		end else begin
			if (state_q == ST_DEEP && deep_state_brownout_cfg && deep_state_brownout_event) begin
				bor_q <= 1'b1;
			end else if (wr_en && apb_req.paddr == OFS_DSC) begin
				bor_q <= apb_req.pwdata[DSC_BOR];
			end
			// Software may only clear the release bit
			if (state_q == ST_RUN && deep_enter) begin
				rel_q <= 1'b1;
			end else if (wr_en && apb_req.paddr == OFS_DSC
				&& !apb_req.pwdata[DSC_REL]) begin
				rel_q <= 1'b0;
			end
		end
	end

	// Wake sources survive the deep exit; a true POR or an arm-bit set clears them, a WSRC write loads the written bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wsrc_q <= 16'h0000;
		end else if (wr_en && apb_req.paddr == OFS_DSC
			&& apb_req.pwdata[DSC_ARM]) begin
			// A wake landing in the same cycle still counts
			wsrc_q <= wake_set;
		end else if (wr_en && apb_req.paddr == OFS_WSRC) begin
			wsrc_q <= apb_req.pwdata[15:0] | wake_set;
		end else begin
			wsrc_q <= wsrc_q | wake_set;
		end
	end

	// Retained scratch words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scr0_q <= DATA_W'(SCR_RST);
			scr1_q <= DATA_W'(SCR_RST);
		end else if (wr_en) begin
			if (apb_req.paddr == OFS_SCR0) begin
				scr0_q <= apb_req.pwdata[DATA_W-1:0];
			end
			if (apb_req.paddr == OFS_SCR1) begin
				scr1_q <= apb_req.pwdata[DATA_W-1:0];
			end
		end
	end

	// Deep exit flag; the exit event beats a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dexit_q <= 1'b0;
		end else if (state_q == ST_DEEP && state_d == ST_DEEP_EXIT) begin
			dexit_q <= 1'b1;
		end else if (wr_en && apb_req.paddr == OFS_RCAUSE) begin
			dexit_q <= apb_req.pwdata[RC_DEXIT];
		end
	end

	// Irq 0 qualifier taken at entry, pin tracked during deep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq0_en_q <= 1'b0;
			irq0_prev_q <= 1'b0;
		end else begin
			irq0_prev_q <= irq0_pin;
			if (state_q == ST_RUN && deep_enter) begin
				irq0_en_q <= irq0_en;
			end else if (state_q != ST_DEEP) begin
				irq0_en_q <= 1'b0;
			end
		end
	end

	// Clock source and pin state captured at entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_hold_q <= 3'h0;
			io_hold_q <= '0;
		end else if (state_q == ST_RUN && state_d != ST_RUN) begin
			clk_hold_q <= clk_sel_in;
			if (!rel_q) begin
				io_hold_q <= io_in;
			end
		end
	end

	// Clock and power gates, aligned with the state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sysclk_en <= 1'b1;
			osc_en <= 1'b1;
			cpu_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			low_power_rc_osc_en <= 1'b0;
			failsafe_clock_monitor_active <= 1'b0;
			mem_pwr_en <= 1'b1;
		end else begin
			sysclk_en <= (state_d == ST_RUN) || (state_d == ST_IDLE)
				|| (state_d == ST_DEEP_EXIT);
			osc_en <= (state_d != ST_SLEEP) && (state_d != ST_DEEP);
			cpu_clk_en <= (state_d == ST_RUN);
			periph_clk_en <= (state_d == ST_RUN)
				|| (state_d == ST_IDLE);
			mem_pwr_en <= (state_d != ST_DEEP);
			failsafe_clock_monitor_active <= failsafe_clock_monitor_enable && (state_d == ST_RUN
				|| state_d == ST_IDLE);
			case (state_d)
				ST_SLEEP: low_power_rc_osc_en <= wdt_enable & wdt_on_low_power_rc_osc;
				ST_IDLE: low_power_rc_osc_en <= wdt_enable | failsafe_clock_monitor_enable;
				ST_DEEP: low_power_rc_osc_en <= 1'b0;
				default: low_power_rc_osc_en <= wdt_enable | failsafe_clock_monitor_enable;
			endcase
		end
	end

	// One-cycle event pulses to the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_clear <= 1'b0;
			cpu_resume <= 1'b0;
			irq_flush <= 1'b0;
			por_rearm <= 1'b0;
		end else begin
			wdt_clear <= wdt_enable && state_q == ST_RUN
				&& (state_d == ST_SLEEP || state_d == ST_IDLE);
			cpu_resume <= (state_q == ST_IDLE || state_q == ST_SLEEP)
				&& state_d == ST_RUN;
			irq_flush <= (state_q == ST_RUN) && deep_enter;
			por_rearm <= (state_q == ST_DEEP) && deep_state_brownout_cfg
				&& deep_state_brownout_event;
		end
	end

	// Core reset held through the POR sequence after deep exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_rst_n <= 1'b0;
		end else begin
			core_rst_n <= (state_d != ST_DEEP_EXIT);
		end
	end

	// Resume clock and pin drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_sel_out <= 3'h0;
			io_out <= '0;
			io_frozen <= 1'b0;
		end else begin
			// Held value keeps the source used before sleeping
			clk_sel_out <= (state_d == ST_RUN && state_q == ST_RUN)
				? clk_sel_in : clk_hold_q;
			// Idle leaves the pins to the running peripherals
			if (state_d == ST_IDLE && !rel_q) begin
				io_frozen <= 1'b0;
				io_out <= io_in;
			end else if (state_q == ST_RUN && state_d != ST_RUN) begin
				io_frozen <= 1'b1;
				io_out <= rel_q ? io_hold_q : io_in;
			end else if (state_d != ST_RUN || rel_q) begin
				io_frozen <= 1'b1;
				io_out <= io_hold_q;
			end else begin
				io_frozen <= 1'b0;
				io_out <= io_in;
			end
		end
	end

	// APB answer; read data sampled in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready <= 1'b1;
			if (rd_setup) begin
				apb_rsp.pslverr <= ~addr_ok;
				apb_rsp.prdata <= RD_ZERO;
				case (apb_req.paddr)
					OFS_DSC: begin
						apb_rsp.prdata[DSC_ARM] <= arm_q;
						apb_rsp.prdata[DSC_BOR] <= bor_q;
						apb_rsp.prdata[DSC_REL] <= rel_q;
					end
					OFS_WSRC: apb_rsp.prdata[15:0] <= wsrc_q;
					OFS_SCR0: apb_rsp.prdata[DATA_W-1:0] <= scr0_q;
					OFS_SCR1: apb_rsp.prdata[DATA_W-1:0] <= scr1_q;
					OFS_RCAUSE: apb_rsp.prdata[RC_DEXIT] <= dexit_q;
					OFS_STAT: apb_rsp.prdata[2:0] <= state_q;
					default: apb_rsp.prdata <= RD_ZERO;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/pmc_sva.sv
`default_nettype none
module pmc_sva (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic psave_req, // Save taken
	input wire logic psave_mode, // Operand
	input wire logic irq_wake, // Irq pending
	input wire logic dev_reset_req, // Reset event
	input wire logic wdt_enable, // Watchdog on
	input wire logic wdt_timeout, // Watchdog fired
	input wire logic failsafe_clock_monitor_enable, // Monitor on
	input wire logic master_clear_pin_pin_n, // Clear pin
	input wire pmc_pkg::pmc_io_t io_out, // Pads
	input wire logic sysclk_en, // Sys clock
	input wire logic osc_en, // Oscillator
	input wire logic cpu_clk_en, // CPU gate
	input wire logic periph_clk_en, // Periph gate
	input wire logic low_power_rc_osc_en, // RC osc
	input wire logic failsafe_clock_monitor_active, // Monitor
	input wire logic io_frozen, // Pins held
	input wire logic wdt_clear, // Wdt clear
	input wire logic cpu_resume, // Fetch pulse
	input wire logic irq_flush, // Flush pulse
	input wire logic mem_pwr_en, // Memory power
	input wire logic core_rst_n // Core reset
);
	timeunit 1ns;
	timeprecision 1ps;
	import pmc_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Clock off means every clocked consumer is off as well
	a_sleep_gates: assert property (!sysclk_en && core_rst_n |->
		!osc_en && !cpu_clk_en && !periph_clk_en && !failsafe_clock_monitor_active)
		else $error("gate left on with clock off");
	a_idle_run: assert property (!cpu_clk_en && sysclk_en && core_rst_n |->
		periph_clk_en && (low_power_rc_osc_en || !(wdt_enable || failsafe_clock_monitor_enable)))
		else $error("idle gating wrong");
	a_pin_freeze: assert property (!sysclk_en && !$past(sysclk_en) |->
		$stable(io_out))
		else $error("pins moved while frozen");
	a_wdt_clear: assert property (psave_req && cpu_clk_en &&
		core_rst_n && wdt_enable |=> wdt_clear || !mem_pwr_en)
		else $error("no watchdog clear on entry");
	a_sleep_wake: assert property (!sysclk_en && mem_pwr_en &&
		(irq_wake || wdt_timeout || dev_reset_req) |=> sysclk_en)
		else $error("sleep not left");
	// Coincident interrupt must not stop the entry, only end it
	a_idle_wake: assert property (psave_req && psave_mode && cpu_clk_en &&
		core_rst_n && irq_wake |=> !cpu_clk_en ##1 cpu_clk_en && cpu_resume)
		else $error("coincident irq handling wrong");
	a_deep_entry: assert property ($fell(mem_pwr_en) |->
		irq_flush && io_frozen && !sysclk_en)
		else $error("deep entry incomplete");
	a_deep_exit: assert property (!mem_pwr_en && !master_clear_pin_pin_n |=> !core_rst_n)
		else $error("clear pin did not end deep");
	a_por_hold: assert property ($fell(core_rst_n) |->
		!core_rst_n [*4] ##[1:2] core_rst_n)
		else $error("power-on sequence length wrong");

	c_deep: cover property ($fell(mem_pwr_en));
	c_idle: cover property (!cpu_clk_en && sysclk_en);
	c_exit: cover property ($rose(core_rst_n));
endmodule
bind pmc_top pmc_sva u_sva (.*);
`default_nettype wire

// File: testbench/pmc_core_model.sv
`default_nettype none
module pmc_core_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic go, // Bench asks for save
	input wire logic mode, // 0 sleep, 1 idle
	output logic psave_req, // Save executed
	output logic psave_mode, // Operand
	output logic instr_tick // Instruction cycle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] tick_q;
	// Save follows the arm write at once, inside the arm window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psave_req <= 1'b0;
			psave_mode <= 1'b0;
		end else begin
			psave_req <= go;
			psave_mode <= mode;
		end
	end
	// One instruction cycle per eight clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_q <= 3'h0;
			instr_tick <= 1'b0;
		end else begin
			tick_q <= tick_q + 3'h1;
			instr_tick <= tick_q == 3'h7;
		end
	end
endmodule
`default_nettype wire

// File: testbench/tb_power_mode_controller.sv
`default_nettype none
module tb_power_mode_controller;
	timeunit 1ns;
	timeprecision 1ps;
	import pmc_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, go = 1'b0, mode = 1'b0;
	logic irq_wake = 1'b0, rst_req = 1'b0, wdt_to = 1'b0, master_clear_pin_n = 1'b1;
	logic irq0 = 1'b0, deep_state_watchdog = 1'b0, por = 1'b0, bor = 1'b0;
	logic wdt_en = 1'b1, failsafe_clock_monitor_en = 1'b1, irq0_pol = 1'b1, rearm;
	localparam int POR_N = 4;
	logic psave_req, psave_mode, instr_tick, frz, sck, osc, cpu, per;
	logic low_power_rc_osc, failsafe_clock_monitor, mem, crst;
	logic [2:0] sel_in = 3'h0, clk_sel_out;
	logic [6:0] gv;
	logic [32:0] r;
	logic [31:0] d;
	pmc_apb_req_t req = '0;
	pmc_apb_rsp_t rsp;
	pmc_io_t io_in = '0, io_out;
	integer seed = 67859, err_total = 0, n_compared = 0, tmo = 0;
	assign gv = {sck, osc, cpu, per, low_power_rc_osc, failsafe_clock_monitor, frz};

	initial forever #10 pclk = ~pclk;

	pmc_core_model CORE (.pclk(pclk), .presetn(presetn), .go(go),
		.mode(mode), .psave_req(psave_req), .psave_mode(psave_mode),
		.instr_tick(instr_tick));
	// Config moves only while running, so the gates settle before use
	pmc_top #(.POR_CYC(POR_N)) DUT (.pclk(pclk), .presetn(presetn),
		.apb_req(req), .apb_rsp(rsp), .psave_req(psave_req),
		.psave_mode(psave_mode), .instr_tick(instr_tick),
		.irq_wake(irq_wake), .dev_reset_req(rst_req), .wdt_enable(wdt_en),
		.wdt_on_low_power_rc_osc(1'b1), .failsafe_clock_monitor_enable(failsafe_clock_monitor_en), .wdt_timeout(wdt_to),
		.master_clear_pin_pin_n(master_clear_pin_n), .irq0_pin(irq0), .irq0_en(1'b1),
		.irq0_pol(irq0_pol), .deep_state_watchdog_timeout(deep_state_watchdog), .por_event(por),
		.deep_state_brownout_event(bor), .deep_state_brownout_cfg(1'b1), .clk_sel_in(sel_in),
		.io_in(io_in), .io_out(io_out), .io_frozen(frz), .sysclk_en(sck),
		.osc_en(osc), .cpu_clk_en(cpu), .periph_clk_en(per),
		.low_power_rc_osc_en(low_power_rc_osc), .failsafe_clock_monitor_active(failsafe_clock_monitor), .wdt_clear(),
		.clk_sel_out(clk_sel_out), .cpu_resume(), .irq_flush(),
		.mem_pwr_en(mem), .core_rst_n(crst), .por_rearm(rearm));

	task automatic end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; r takes {pslverr, prdata} at the ready edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, wd};
		@(posedge pclk);
		req.penable <= 1'b1;
		// No bound here; the hang guard ends a stuck bus
		do begin
			@(posedge pclk);
		end while (rsp.pready !== 1'b1);
		r = {rsp.pslverr, rsp.prdata};
		req <= '0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, {1'b0, e});
	endtask

	task automatic cyc(input integer n);
		repeat (n) @(posedge pclk);
	endtask

	// Expected {sys, osc, cpu, periph, rc, monitor, frozen}
	function automatic logic [6:0] gates(input integer m, input logic w,
		input logic f);
		case (m)
			0: gates = {4'h0, w, 1'b0, 1'b1};
			1: gates = {4'hD, w | f, f, 1'b0};
			default: gates = {4'hF, w | f, f, 1'b0};
		endcase
	endfunction

	// Wake-source bit for each deep exit cause
	function automatic logic [31:0] wsrc(input integer k);
		wsrc = 32'h0000_0001 << (k == 0 ? WS_MASTER_CLEAR_PIN : k == 1 ? WS_WDT :
			k == 2 ? WS_EXTERNAL_IRQ_ZERO : WS_POR);
	endfunction

	// Hang guard, far above the few hundred cycles needed
	always @(posedge pclk) begin
		tmo <= tmo + 1;
		if (tmo == 20000) begin
			err_total++;
			end_of_test;
		end
	end

	initial begin
		integer m, s, k, e;
		logic [2:0] sel;
		pmc_io_t hold;
		cyc(10);
		presetn <= 1'b1;
		cyc(2);
		for (k = 0; k < 6; k++) rd(12'(k * 4), 32'h0000_0000);
		chk(33'(gv), 33'(gates(2, 1'b1, 1'b1)));
		apb(1'b0, 12'h018, 32'h0000_0000);
		chk(r, 33'h1_0000_0000);
		d = $random(seed);
		apb(1'b1, OFS_SCR1, d);
		rd(OFS_SCR1, {16'h0000, d[15:0]});
		// Sleep and idle, each left by every wake cause
		for (m = 0; m < 2; m++)
			for (s = 0; s < 3; s++) begin
				sel = 3'($random(seed));
				@(posedge pclk);
				io_in <= $random(seed);
				sel_in <= sel;
				go <= 1'b1;
				mode <= m[0];
				wdt_en <= s != 1;
				failsafe_clock_monitor_en <= s != 2;
				@(posedge pclk);
				go <= 1'b0;
				hold = io_in;
				cyc(3);
				@(negedge pclk);
				chk(33'(gv), 33'(gates(m, wdt_en, failsafe_clock_monitor_en)));
				@(posedge pclk);
				io_in <= ~hold;
				sel_in <= ~sel;
				cyc(2);
				@(negedge pclk);
				if (m == 0) chk(33'(io_out), 33'(hold));
				@(posedge pclk);
				irq_wake <= s == 0;
				rst_req <= s == 1;
				wdt_to <= s == 2;
				@(posedge pclk);
				{irq_wake, rst_req, wdt_to} <= 3'h0;
				@(negedge pclk);
				chk(33'(gv), 33'(gates(2, wdt_en, failsafe_clock_monitor_en)));
				if (m == 0 && s != 1) chk(33'(clk_sel_out), 33'(sel));
				cyc(2);
				@(negedge pclk);
				chk(33'(io_out), 33'(io_in));
			end
		// Interrupt arriving with the idle request
		@(posedge pclk);
		wdt_en <= 1'b1;
		failsafe_clock_monitor_en <= 1'b1;
		go <= 1'b1;
		mode <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		irq_wake <= 1'b1;
		cyc(2);
		irq_wake <= 1'b0;
		// Deep state, one pass per exit cause
		for (k = 0; k < 4; k++) begin
			d = $random(seed);
			apb(1'b1, OFS_SCR0, d);
			io_in <= $random(seed);
			irq0 <= 1'b0;
			apb(1'b1, OFS_DSC, 32'h0000_8000);
			go <= 1'b1;
			mode <= 1'b0;
			@(posedge pclk);
			go <= 1'b0;
			cyc(3);
			@(negedge pclk);
			chk(33'({mem, frz}), 33'h0_0000_0001);
			// Move the pin settings; the pads must not follow
			@(posedge pclk);
			hold = io_in;
			io_in <= ~io_in;
			if (k == 0) begin
				@(posedge pclk);
				bor <= 1'b1;
				@(posedge pclk);
				bor <= 1'b0;
				@(negedge pclk);
				chk(33'(rearm), 33'h0_0000_0001);
				cyc(2);
				@(negedge pclk);
				chk(33'(mem), 33'h0_0000_0000);
			end
			@(posedge pclk);
			master_clear_pin_n <= k != 0;
			deep_state_watchdog <= k == 1;
			irq0 <= k == 2;
			por <= k == 3;
			@(posedge pclk);
			master_clear_pin_n <= 1'b1;
			deep_state_watchdog <= k != 1;
			por <= 1'b0;
			@(posedge pclk);
			deep_state_watchdog <= 1'b0;
			for (e = 0; e < 40 && crst !== 1'b1; e++) @(posedge pclk);
			chk(33'(e), 33'(POR_N));
			rd(OFS_WSRC, wsrc(k));
			if (k != 3) begin
				rd(OFS_RCAUSE, 32'h0000_0400);
				rd(OFS_DSC, k == 0 ? 32'h0000_0003 : 32'h0000_0001);
				rd(OFS_SCR0, {16'h0000, d[15:0]});
				chk(33'(frz), 33'h0_0000_0001);
				chk(33'(io_out), 33'(hold));
			end
			apb(1'b1, OFS_DSC, 32'h0000_0000);
			apb(1'b1, OFS_RCAUSE, 32'h0000_0000);
			rd(OFS_RCAUSE, 32'h0000_0000);
			// Core model gives one instruction cycle per eight clocks
			cyc(REENTRY_TCY * 8);
			@(negedge pclk);
			chk({frz, io_out}, {1'b0, io_in});
		end
		apb(1'b1, OFS_DSC, 32'h0000_8000);
		rd(OFS_WSRC, 32'h0000_0000);
		cyc(20);
		rd(OFS_DSC, 32'h0000_0000);
		end_of_test;
	end
endmodule
`default_nettype wire
